// [hdl/sbc_ctrl.sv]
// sbc_ctrl: local memory controller for up to four external sram banks
// assumes all requesters and the sram run on clk; strap pins are asynchronous
//
// Operation
// - One to four banks, each at most 2 Mbytes, all same size.
// - Capacity field, general_config bits 9:7, places banks contiguously.
// - Code 000 is 64 KB on bits 17:16; each step doubles; 110/111 reserved.
// - Every internal requester access is a full 32-bit word; processor writes use its byte enables.
// - Up to 8 Mbytes addressed, minus the low 200h bytes (1000h in stand-alone).
// - Registers and device windows sit at the bottom, served by this controller.
// - Width select low runs by_4/by_8 parts, high runs by_16 parts.
// - In by_16 mode write strobes are byte enables on reads and writes.
// - Device windows only in stand-alone; else 200h-fffh is bank 0 memory.
// - Wait select bit 10: 0 gives one-cycle, 1 gives two-cycle access.
// - Wait select resets to 1.
// - Processor register accesses take the same timing as its sram accesses.
// - PCI register accesses always take zero wait states.
// - Priority: reassembly, segmentation, PCI, then local processor.
`timescale 1ns/100ps
`default_nettype none

module sbc_ctrl (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // straps
  input  wire logic        sram_width_select,
  input  wire logic        local_cpu_mode_select,
  // reassembly consumer
  input  wire logic        reassembly_consumer_req,
  input  wire logic        reassembly_consumer_we,
  input  wire logic [22:0] reassembly_consumer_addr,
  input  wire logic [31:0] reassembly_consumer_wdata,
  output logic             reassembly_consumer_done,
  // segmentation consumer
  input  wire logic        segmentation_consumer_req,
  input  wire logic        segmentation_consumer_we,
  input  wire logic [22:0] segmentation_consumer_addr,
  input  wire logic [31:0] segmentation_consumer_wdata,
  output logic             segmentation_consumer_done,
  // pci slave path
  input  wire logic        pci_req,
  input  wire logic        pci_we,
  input  wire logic [22:0] pci_addr,
  input  wire logic [31:0] pci_wdata,
  output logic             pci_done,
  // local processor
  input  wire logic        cpu_chip_select_n,
  input  wire logic        cpu_addr_strobe_n,
  input  wire logic        cpu_we,
  input  wire logic [1:0]  bank_select_inputs,
  input  wire logic [22:0] cpu_addr,
  input  wire logic [3:0]  cpu_byte_en_n,
  input  wire logic [31:0] cpu_wdata,
  output logic             cpu_ready_n,
  // read data shared by all requesters
  output logic [31:0]      rd_data,
  // sram and device pins
  output logic [20:0]      sram_word_addr,
  output logic [3:0]       bank_chip_selects_n,
  output logic             sram_out_en_n,
  output logic [3:0]       sram_write_strobes_n,
  output logic [31:0]      sram_data_out,
  output logic             sram_data_oe_n,
  input  wire logic [31:0] sram_data_in,
  output logic             ext_dev_select_n
);

  typedef struct packed {
    sbc_pkg::sbc_state_t st;
    logic [2:0]          wsel_s;
    logic [2:0]          mode_s;
    logic                by16;
    logic                standalone;
    logic [31:0]         cfg;
    logic                cpu_pend;
    logic                cpu_we;
    logic [22:0]         cpu_addr;
    logic [3:0]          cpu_be;
    logic [31:0]         cpu_wdata;
    sbc_pkg::sbc_src_t   src;
    sbc_pkg::sbc_tgt_t   tgt;
    logic                we;
    logic [22:0]         addr;
    logic [31:0]         wdata;
    logic [3:0]          be;
    logic [1:0]          bank;
    logic [20:0]         sram_addr;
    logic [3:0]          cs_n;
    logic                oe_n;
    logic [3:0]          wstb_n;
    logic [31:0]         dout;
    logic                dout_n;
    logic                dev_n;
    logic [31:0]         rdata;
    logic                rsm_done;
    logic                seg_done;
    logic                pci_done;
    logic                cpu_rdy_n;
  } sbc_regs_t;

  sbc_regs_t q;
  sbc_regs_t d;

  logic                slow;
  logic [2:0]          cap;

  // wait state applies unless pci reaches a register
  assign slow = q.cfg[sbc_pkg::CFG_WAIT_BIT]
                && !(q.src == sbc_pkg::SRC_PCI && q.tgt == sbc_pkg::TGT_REG);
  assign cap  = q.cfg[sbc_pkg::CFG_CAP_LSB +: 3];

  // next state of the whole controller
  always_comb begin
    logic        grant;
    logic [22:0] a;
    d           = q;
    d.rsm_done  = 1'b0;
    d.seg_done  = 1'b0;
    d.pci_done  = 1'b0;
    d.cpu_rdy_n = 1'b1;
    grant       = 1'b0;
    a           = '0;

    // strap filters: a change counts once stages two and three agree
    d.wsel_s = {q.wsel_s[1:0], sram_width_select};
    d.mode_s = {q.mode_s[1:0], local_cpu_mode_select};
    if (q.wsel_s[2] == q.wsel_s[1]) d.by16 = q.wsel_s[2];
    if (q.mode_s[2] == q.mode_s[1]) d.standalone = q.mode_s[2];

    // processor request taken when chip select and address strobe are low
    if (!cpu_chip_select_n && !cpu_addr_strobe_n && !q.cpu_pend) begin
      a = cpu_addr;
      a[sbc_pkg::BANK_BIT_BASE + int'(sbc_pkg::cap_clamp(cap)) +: 2] = bank_select_inputs;
      d.cpu_pend  = 1'b1;
      d.cpu_we    = cpu_we;
      d.cpu_addr  = a;
      d.cpu_be    = ~cpu_byte_en_n;
      d.cpu_wdata = cpu_wdata;
    end

    unique case (q.st)
      sbc_pkg::ST_IDLE: begin
        // fixed priority arbitration
        grant = 1'b1;
        if (reassembly_consumer_req) begin
          d.src = sbc_pkg::SRC_RSM;
          d.we = reassembly_consumer_we;
          d.addr = reassembly_consumer_addr;
          d.wdata = reassembly_consumer_wdata;
          d.be = 4'hf;
        end else if (segmentation_consumer_req) begin
          d.src = sbc_pkg::SRC_SEG;
          d.we = segmentation_consumer_we;
          d.addr = segmentation_consumer_addr;
          d.wdata = segmentation_consumer_wdata;
          d.be = 4'hf;
        end else if (pci_req) begin
          d.src = sbc_pkg::SRC_PCI;
          d.we = pci_we;
          d.addr = pci_addr;
          d.wdata = pci_wdata;
          d.be = 4'hf;
        end else if (q.cpu_pend) begin
          d.src = sbc_pkg::SRC_CPU;
          d.we = q.cpu_we;
          d.addr = q.cpu_addr;
          d.wdata = q.cpu_wdata;
          d.be = q.cpu_be;
        end else begin
          grant = 1'b0;
        end
        if (grant) begin
          // registers and device windows decoded from the low addresses
          d.tgt  = sbc_pkg::target_of(d.addr, q.standalone);
          d.bank = sbc_pkg::bank_of(d.addr, cap);
          d.st   = sbc_pkg::ST_ACC1;
          if (d.tgt != sbc_pkg::TGT_REG) begin
            d.sram_addr = d.addr[22:2];
            d.oe_n      = d.we;
            d.dout      = d.wdata;
            d.dout_n    = !d.we;
            if (d.we) d.wstb_n = ~d.be;
            else d.wstb_n = q.by16 ? 4'h0 : 4'hf;
            if (d.tgt == sbc_pkg::TGT_DEV) d.dev_n = 1'b0;
            else d.cs_n = ~(4'h1 << d.bank);
          end
        end
      end
      sbc_pkg::ST_ACC1, sbc_pkg::ST_ACC2: begin
        if (q.st == sbc_pkg::ST_ACC1 && slow) begin
          d.st = sbc_pkg::ST_ACC2;  // pins stay put
        end else begin
          // finish: sample data, update registers, release pins
          d.st = sbc_pkg::ST_IDLE;
          if (q.tgt == sbc_pkg::TGT_REG) begin
            if (q.addr == sbc_pkg::CFG_OFS) d.rdata = q.cfg;
            else if (q.addr == sbc_pkg::STAT_OFS)
              d.rdata = {24'h0, q.by16, q.standalone, q.bank, 1'b0, cap};
            else d.rdata = 32'h0;
            if (q.we && q.addr == sbc_pkg::CFG_OFS) begin
              for (int i = 0; i < 4; i++) begin
                if (q.be[i]) d.cfg[i*8 +: 8] = q.wdata[i*8 +: 8];
              end
            end
          end else begin
            d.rdata = sram_data_in;
          end
          d.cs_n   = 4'hf;
          d.oe_n   = 1'b1;
          d.wstb_n = 4'hf;
          d.dout_n = 1'b1;
          d.dev_n  = 1'b1;
          unique case (q.src)
            sbc_pkg::SRC_RSM: d.rsm_done = 1'b1;
            sbc_pkg::SRC_SEG: d.seg_done = 1'b1;
            sbc_pkg::SRC_PCI: d.pci_done = 1'b1;
            sbc_pkg::SRC_CPU: begin
              d.cpu_rdy_n = 1'b0;
              d.cpu_pend  = 1'b0;
            end
          endcase
        end
      end
      default: d.st = sbc_pkg::ST_IDLE;
    endcase

    if (rst) begin
      d           = '0;
      d.cfg       = sbc_pkg::CFG_RESET;
      d.cs_n      = 4'hf;
      d.oe_n      = 1'b1;
      d.wstb_n    = 4'hf;
      d.dout_n    = 1'b1;
      d.dev_n     = 1'b1;
      d.cpu_rdy_n = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    q <= d;
  end

  // outputs straight from the state register
  assign reassembly_consumer_done   = q.rsm_done;
  assign segmentation_consumer_done = q.seg_done;
  assign pci_done                   = q.pci_done;
  assign cpu_ready_n                = q.cpu_rdy_n;
  assign rd_data                    = q.rdata;
  assign sram_word_addr             = q.sram_addr;
  assign bank_chip_selects_n        = q.cs_n;
  assign sram_out_en_n              = q.oe_n;
  assign sram_write_strobes_n       = q.wstb_n;
  assign sram_data_out              = q.dout;
  assign sram_data_oe_n             = q.dout_n;
  assign ext_dev_select_n           = q.dev_n;

  // checks on the controller's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_acc_start;
    q.st == sbc_pkg::ST_ACC1;
  endsequence

  sequence s_slow_start;
    q.st == sbc_pkg::ST_ACC1 && slow && q.tgt == sbc_pkg::TGT_SRAM;
  endsequence

  a_one_bank_sel: assert property ($onehot0(~q.cs_n))
    else $error("more than one bank chip select active");
  a_bank_decode: assert property (s_acc_start and q.tgt == sbc_pkg::TGT_SRAM |->
    q.cs_n == ~(4'h1 << sbc_pkg::bank_of(q.addr, cap)))
    else $error("bank chip select does not match capacity decode");
  a_full_word: assert property (s_acc_start and q.src != sbc_pkg::SRC_CPU && q.we
    && q.tgt != sbc_pkg::TGT_REG |-> q.wstb_n == 4'h0)
    else $error("internal write is not a full word");
  a_by16_read_en: assert property (s_acc_start and !q.we && q.by16
    && q.tgt != sbc_pkg::TGT_REG |-> q.wstb_n == 4'h0)
    else $error("by_16 read without byte enables");
  a_by8_read_idle: assert property (s_acc_start and !q.we && !q.by16
    && q.tgt != sbc_pkg::TGT_REG |-> q.wstb_n == 4'hf)
    else $error("by_8 read drives write strobes");
  a_slow_hold: assert property (s_slow_start |=> q.st == sbc_pkg::ST_ACC2
    && $stable(q.sram_addr) && $stable(q.cs_n) ##1 q.cs_n == 4'hf)
    else $error("wait-state access did not hold pins two cycles");
  a_fast_done: assert property (s_acc_start and !q.cfg[sbc_pkg::CFG_WAIT_BIT]
    && q.src == sbc_pkg::SRC_RSM |=> q.rsm_done)
    else $error("zero-wait access took more than one cycle");
  a_pci_reg_fast: assert property (s_acc_start and q.src == sbc_pkg::SRC_PCI
    && q.tgt == sbc_pkg::TGT_REG |=> q.pci_done)
    else $error("pci register access was delayed");
  a_cpu_reg_wait: assert property (s_acc_start and q.src == sbc_pkg::SRC_CPU
    && q.tgt == sbc_pkg::TGT_REG && q.cfg[sbc_pkg::CFG_WAIT_BIT] |=> q.cpu_rdy_n ##1 !q.cpu_rdy_n)
    else $error("processor register access ignored the wait state");
  a_reset_wait: assert property ($past(rst) |-> q.cfg[sbc_pkg::CFG_WAIT_BIT])
    else $error("wait select not set after reset");
  a_rsm_first: assert property (q.st == sbc_pkg::ST_IDLE && reassembly_consumer_req
    |=> q.src == sbc_pkg::SRC_RSM)
    else $error("reassembly request lost arbitration");
  a_low_map: assert property (s_acc_start and !q.standalone && q.addr >= sbc_pkg::REG_TOP
    && q.addr < sbc_pkg::DEV_TOP |-> q.dev_n && !q.cs_n[0])
    else $error("device window used with a local processor");

endmodule

`default_nettype wire

// [hdl/sbc_pkg.sv]
// sbc_pkg: constants, types and decode helpers of the sram bank controller
// assumes a single 100 MHz system clock; byte addresses are 23 bits (8 Mbytes)
package sbc_pkg;

  // address space
  localparam int              ADDR_W    = 23;
  localparam logic [22:0]     CFG_OFS   = 23'h000014;  // general_config
  localparam logic [22:0]     STAT_OFS  = 23'h000018;  // controller status
  localparam logic [22:0]     REG_TOP   = 23'h000200;  // registers below this
  localparam logic [22:0]     DEV_TOP   = 23'h001000;  // device windows below this

  // general_config fields and reset value
  localparam int              CFG_WAIT_BIT = 10;
  localparam int              CFG_CAP_LSB  = 7;
  localparam logic [31:0]     CFG_RESET    = 32'h0000_0400;  // one wait state

  // bank capacity coding
  localparam logic [2:0]      CAP_MAX       = 3'h5;   // 512K x 32, 2 Mbytes
  localparam int              BANK_BIT_BASE = 16;     // select bits of code 000

  typedef enum logic [1:0] {ST_IDLE, ST_ACC1, ST_ACC2} sbc_state_t;
  typedef enum logic [1:0] {SRC_RSM, SRC_SEG, SRC_PCI, SRC_CPU} sbc_src_t;
  typedef enum logic [1:0] {TGT_SRAM, TGT_REG, TGT_DEV} sbc_tgt_t;

  // reserved capacity codes act as the largest bank
  function automatic logic [2:0] cap_clamp(input logic [2:0] code);
    return (code > CAP_MAX) ? CAP_MAX : code;
  endfunction

  // bank number held in the two address bits that the capacity code names
  function automatic logic [1:0] bank_of(input logic [22:0] addr, input logic [2:0] code);
    logic [22:0] s;
    s = addr >> (BANK_BIT_BASE + int'(cap_clamp(code)));
    return s[1:0];
  endfunction

  // region that a byte address falls into
  function automatic sbc_tgt_t target_of(input logic [22:0] addr, input logic standalone);
    if (addr < REG_TOP) return TGT_REG;
    if (addr < DEV_TOP && standalone) return TGT_DEV;
    return TGT_SRAM;
  endfunction

endpackage

// [sim/sbc_ctrl_bench.sv]
// sbc_ctrl_bench: self-checking bench of the sram bank controller
// assumes sbc_sram_model on the sram pins; inputs change at the falling edge
`timescale 1ns/100ps
`default_nettype none
module sbc_ctrl_bench;
  logic        clk = 1'b0, rst = 1'b1, ws = 1'b0, md = 1'b0;
  logic        req [3] = '{default: 1'b0};
  logic        we [3] = '{default: 1'b0};
  logic        dn [3];
  logic [22:0] ad [3] = '{default: 23'h0};
  logic [31:0] wd [3] = '{default: 32'h0};
  logic        csn = 1'b1, asn = 1'b1, cwe = 1'b0, dev_seen = 1'b0, rdyn, oen, doen, devn;
  logic        rd_doe = 1'b0, wr_doe = 1'b1;
  logic [1:0]  bs = 2'h0;
  logic [22:0] ca = 23'h0;
  logic [31:0] cd = 32'h0, rdat, got, dout, din;
  logic [20:0] wa;
  logic [3:0]  bcs, wsn, cs_seen = 4'hf, rd_stb = 4'h5, wr_stb = 4'h5;
  int          compares = 0, miscompares = 0, n;

  // design and sram banks
  sbc_ctrl DUT (
    .clk(clk), .rst(rst), .sram_width_select(ws), .local_cpu_mode_select(md),
    .reassembly_consumer_req(req[0]), .reassembly_consumer_we(we[0]),
    .reassembly_consumer_addr(ad[0]), .reassembly_consumer_wdata(wd[0]),
    .reassembly_consumer_done(dn[0]), .segmentation_consumer_req(req[1]),
    .segmentation_consumer_we(we[1]), .segmentation_consumer_addr(ad[1]),
    .segmentation_consumer_wdata(wd[1]), .segmentation_consumer_done(dn[1]),
    .pci_req(req[2]), .pci_we(we[2]), .pci_addr(ad[2]), .pci_wdata(wd[2]), .pci_done(dn[2]),
    .cpu_chip_select_n(csn), .cpu_addr_strobe_n(asn), .cpu_we(cwe), .bank_select_inputs(bs),
    .cpu_addr(ca), .cpu_byte_en_n(4'h0), .cpu_wdata(cd), .cpu_ready_n(rdyn), .rd_data(rdat),
    .sram_word_addr(wa), .bank_chip_selects_n(bcs), .sram_out_en_n(oen),
    .sram_write_strobes_n(wsn), .sram_data_out(dout), .sram_data_oe_n(doen),
    .sram_data_in(din), .ext_dev_select_n(devn));
  sbc_sram_model SRAM (
    .clk(clk), .sram_word_addr(wa), .bank_chip_selects_n(bcs), .sram_out_en_n(oen),
    .sram_write_strobes_n(wsn), .sram_data_out(dout), .sram_data_in(din));

  // clock and pin recorder
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (bcs !== 4'hf) cs_seen <= bcs;
    if (devn === 1'b0) dev_seen <= 1'b1;
    if (oen === 1'b0) begin
      rd_stb <= wsn;
      rd_doe <= doen;
    end else if (wsn !== 4'hf) begin
      wr_stb <= wsn;
      wr_doe <= doen;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one word through requester i; n ends as cycles from taking edge to done
  task automatic rq(input int i, input logic w, input logic [22:0] a, input logic [31:0] d);
    n = 0;
    req[i] = 1'b1;
    we[i] = w;
    ad[i] = a;
    wd[i] = d;
    do begin
      @(negedge clk);
      n++;
    end while (dn[i] !== 1'b1 && n < 50);
    req[i] = 1'b0;
    got = rdat;
    n = n - 1;
    // idle cycle so that a following call never re-raises req in the same step
    @(negedge clk);
  endtask

  // processor access: strobes low for one edge, then wait for ready
  task automatic cpu(input logic w, input logic [1:0] b, input logic [22:0] a);
    n = 0;
    csn = 1'b0;
    asn = 1'b0;
    cwe = w;
    bs = b;
    ca = a;
    do begin
      @(negedge clk);
      n++;
      csn = 1'b1;
      asn = 1'b1;
    end while (rdyn !== 1'b0 && n < 50);
    got = rdat;
    n = n - 1;
    // idle cycle so that a following call never re-lowers the strobes in the same step
    @(negedge clk);
  endtask

  task automatic cfg(input logic w, input logic [2:0] c);
    rq(2, 1'b1, 23'h14, {21'h0, w, c, 7'h0});
  endtask

  task automatic t_wait;
    cpu(1'b0, 2'h0, 23'h14);
    chk("config reset", 32'h400, got);
    chk("cpu reg cycles", 32'h3, n);
    rq(2, 1'b0, 23'h14, 32'h0);
    chk("pci reg cycles", 32'h1, n);
    rq(0, 1'b1, 23'h2000, 32'h1234_5678);
    chk("write strobes", 32'h0, {28'h0, wr_stb});
    chk("write data drive", 32'h0, {31'h0, wr_doe});
    chk("wait write cycles", 32'h2, n);
    cpu(1'b0, 2'h0, 23'h2000);
    chk("cpu sram data", 32'h1234_5678, got);
    chk("read data release", 32'h1, {31'h0, rd_doe});
    chk("cpu sram cycles", 32'h3, n);
    cfg(1'b0, 3'h0);
    rq(0, 1'b0, 23'h2000, 32'h0);
    chk("zero wait data", 32'h1234_5678, got);
    chk("zero wait cycles", 32'h1, n);
    cpu(1'b0, 2'h0, 23'h14);
    chk("cpu reg zero wait", 32'h2, n);
  endtask

  // every capacity code, reserved ones acting as the largest bank
  task automatic t_banks;
    int e;
    for (int c = 0; c < 8; c++) begin
      e = (c > 5) ? 5 : c;
      cfg(1'b0, c[2:0]);
      for (int b = 0; b < 4; b++) begin
        cs_seen = 4'hf;
        rq(1, 1'b1, (23'(b) << (16 + e)) | 23'h4000, 32'h5a00_0000 | 32'(c * 16 + b));
        chk("bank select", {28'h0, ~(4'h1 << b)}, {28'h0, cs_seen});
      end
      for (int b = 0; b < 4; b++) begin
        rq(0, 1'b0, (23'(b) << (16 + e)) | 23'h4000, 32'h0);
        chk("bank data", 32'h5a00_0000 | 32'(c * 16 + b), got);
      end
      cs_seen = 4'hf;
      cpu(1'b0, 2'h2, 23'h4000);
      chk("cpu bank select", 32'hb, {28'h0, cs_seen});
      chk("cpu bank data", 32'h5a00_0002 | 32'(c * 16), got);
    end
  endtask

  // all four requesters at once; completions must follow priority
  task automatic t_prio;
    int ord [$];
    cfg(1'b0, 3'h0);
    for (int i = 0; i < 3; i++) req[i] = 1'b1;
    csn = 1'b0;
    asn = 1'b0;
    ca = 23'h14;
    cwe = 1'b0;
    repeat (40) begin
      @(negedge clk);
      csn = 1'b1;
      asn = 1'b1;
      for (int i = 0; i < 3; i++)
        if (dn[i] === 1'b1) begin
          ord.push_back(i);
          req[i] = 1'b0;
        end
      if (rdyn === 1'b0) ord.push_back(3);
    end
    chk("grant count", 32'h4, ord.size());
    foreach (ord[i]) chk("grant order", i, ord[i]);
  endtask

  task automatic t_width;
    for (int s = 0; s < 2; s++) begin
      ws = s[0];
      repeat (5) @(negedge clk);
      rd_stb = 4'h5;
      rq(0, 1'b0, 23'h2000, 32'h0);
      chk("read strobes", s ? 32'h0 : 32'hf, {28'h0, rd_stb});
      chk("width data", 32'h1234_5678, got);
    end
    ws = 1'b0;
  endtask

  task automatic t_map;
    for (int m = 0; m < 2; m++) begin
      md = m[0];
      repeat (5) @(negedge clk);
      cs_seen = 4'hf;
      dev_seen = 1'b0;
      rq(0, 1'b0, 23'h300, 32'h0);
      chk("device window", 32'(m), {31'h0, dev_seen});
      chk("window bank", m ? 32'hf : 32'he, {28'h0, cs_seen});
    end
    cs_seen = 4'hf;
    rq(2, 1'b0, 23'h1fc, 32'h0);
    chk("register area data", 32'h0, got);
    chk("register area select", 32'hf, {28'h0, cs_seen});
  endtask

  // reset in mid-run brings the wait select back
  task automatic t_rst;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    cpu(1'b0, 2'h0, 23'h14);
    chk("config after reset", 32'h400, got);
    chk("cpu reg cycles after reset", 32'h3, n);
  endtask

  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // main sequence after ten reset cycles and strap filtering
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_wait;
    t_banks;
    t_prio;
    t_width;
    t_map;
    t_rst;
    print_verdict;
  end

  // watchdog well beyond the expected run of about four hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    print_verdict;
  end
endmodule
`default_nettype wire

// [sim/sbc_sram_model.sv]
// sbc_sram_model: behavioural model of up to four external sram banks
// assumes registered controller pins on clk; read data settles by the falling edge
`timescale 1ns/100ps
`default_nettype none
module sbc_sram_model (
  // clock
  input  wire logic        clk,
  // sram pins from the controller
  input  wire logic [20:0] sram_word_addr,
  input  wire logic [3:0]  bank_chip_selects_n,
  input  wire logic        sram_out_en_n,
  input  wire logic [3:0]  sram_write_strobes_n,
  input  wire logic [31:0] sram_data_out,
  // read data back to the controller
  output var logic [31:0]  sram_data_in
);
  logic [31:0] mem [logic [22:0]];
  logic [31:0] w;
  logic [22:0] kw;
  logic [22:0] kr;

  // storage key: selected bank above the word address
  function automatic logic [22:0] key_of(input logic [3:0] cs, input logic [20:0] wa);
    logic [1:0] b;
    b = 2'h0;
    for (int i = 0; i < 4; i++)
      if (!cs[i]) b = 2'(i);
    return {b, wa};
  endfunction

  // byte-wise store; strobes while the output enable is low never write
  always @(posedge clk) begin
    kw = key_of(bank_chip_selects_n, sram_word_addr);
    if (bank_chip_selects_n !== 4'hf && sram_out_en_n === 1'b1 && sram_write_strobes_n !== 4'hf) begin
      w = mem.exists(kw) ? mem[kw] : 32'h0;
      for (int k = 0; k < 4; k++)
        if (!sram_write_strobes_n[k]) w[8*k +: 8] = sram_data_out[8*k +: 8];
      mem[kw] = w;
    end
  end

  // word while selected and read-enabled, otherwise a bus that toggles every cycle
  initial sram_data_in = 32'h0;
  always @(negedge clk) begin
    kr = key_of(bank_chip_selects_n, sram_word_addr);
    if (bank_chip_selects_n !== 4'hf && sram_out_en_n === 1'b0)
      sram_data_in <= mem.exists(kr) ? mem[kr] : 32'h0bad_f00d;
    else
      sram_data_in <= ~sram_data_in;
  end
endmodule
`default_nettype wire
